// ===== core/flash_host.sv
// APB-controlled host that drives the flash pins and runs toggle polling
//
// The APB slave port and the register addresses are this design's own decisions.
module flash_host
	import flash_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [16:0] flash_addr,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic reset_n,
	output logic a9_hv,
	output logic oe_hv,
	output logic reset_hv
);
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_EVAL} state_e;

	state_e state, next_state;
	op_e op, next_op;
	result_e result, next_result;
	logic [9:0] cnt, next_cnt;
	logic [8:0] hv_age, next_hv_age;
	logic [16:0] addr_reg, next_addr_reg;
	logic [7:0] wdata, next_wdata;
	logic [7:0] rdata, next_rdata;
	logic [7:0] dq_meta, dq_sync;
	logic [3:0] poll_reads, next_poll_reads;
	logic tmp_unprot, next_tmp_unprot;
	logic yield, next_yield;
	logic done, next_done;
	logic poll_n, next_poll_n;
	logic recheck, next_recheck;
	logic rst_cmd, next_rst_cmd;
	logic tog, next_tog;
	logic [16:0] next_flash_addr;
	logic [7:0] next_dq_out;
	logic next_dq_oe, next_ce_n, next_oe_n, next_we_n, next_a9_hv, next_oe_hv, next_reset_hv;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic apb_wr, is_wr, hv_op, hv_full;
	logic [16:0] pin_addr;

	localparam logic [8:0] RSP_MAX = 9'(RSP_CYC);

	// Data pins come from another timing domain
	always_ff @(posedge sys_clk)
	begin
		dq_meta <= dq_in;
		dq_sync <= dq_meta;
	end

	// Bus slave: one wait state so every answer comes from a flop
	always_comb
	begin
		next_pready = psel & penable & ~pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0;
		if (next_pready)
		begin
			case (paddr)
				CTRL_OFF: next_prdata = {29'h0, op};
				ADDR_OFF: next_prdata = {15'h0, addr_reg};
				WDATA_OFF: next_prdata = {24'h0, wdata};
				STATUS_OFF:
				begin
					next_prdata[STAT_BUSY_BIT] = (state != ST_IDLE);
					next_prdata[STAT_DONE_BIT] = done;
					next_prdata[STAT_RES_LSB +: 2] = result;
					next_prdata[STAT_HVRDY_BIT] = hv_full;
					next_prdata[STAT_RDATA_LSB +: 8] = rdata;
				end
				MODE_OFF: next_prdata = {30'h0, yield, tmp_unprot};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// Sequencer and pin drive
	always_comb
	begin
		next_state = state;
		next_op = op;
		next_result = result;
		next_cnt = cnt;
		next_addr_reg = addr_reg;
		next_wdata = wdata;
		next_rdata = rdata;
		next_poll_reads = poll_reads;
		next_tmp_unprot = tmp_unprot;
		next_yield = yield;
		next_done = done;
		next_poll_n = poll_n;
		next_recheck = recheck;
		next_rst_cmd = rst_cmd;
		next_tog = tog;
		apb_wr = psel & penable & pready & pwrite;
		hv_full = (hv_age == RSP_MAX);
		is_wr = rst_cmd || op == OP_WRITE || op == OP_PROTECT || op == OP_UNPROTECT;
		hv_op = !rst_cmd && (op == OP_PROTECT || op == OP_UNPROTECT || op == OP_VERIFY);
		pin_addr = addr_reg;
		if (!rst_cmd && op == OP_VERIFY)
			pin_addr[A1_BIT] = 1'b1;
		if (!rst_cmd && op == OP_PROTECT)
			pin_addr[A6_BIT] = 1'b0;
		if (!rst_cmd && op == OP_UNPROTECT)
			pin_addr[A6_BIT] = 1'b1;
		next_flash_addr = flash_addr;
		next_dq_out = rst_cmd ? RESET_CMD : wdata;
		next_dq_oe = 1'b0;
		next_ce_n = 1'b1;
		next_oe_n = 1'b1;
		next_we_n = 1'b1;
		next_a9_hv = 1'b0;
		next_oe_hv = 1'b0;
		next_reset_hv = tmp_unprot;
		// Age of the reset pin high voltage, saturating
		next_hv_age = reset_hv ? (hv_full ? hv_age : 9'(hv_age + 9'h1)) : 9'h0;
		if (apb_wr && paddr == STATUS_OFF && pwdata[STAT_DONE_BIT])
			next_done = 1'b0;
		// Setup is held constant during an operation, so refuse changes while busy
		if (apb_wr && state == ST_IDLE)
		begin
			case (paddr)
				ADDR_OFF: next_addr_reg = pwdata[16:0];
				WDATA_OFF: next_wdata = pwdata[7:0];
				MODE_OFF:
				begin
					next_tmp_unprot = pwdata[MODE_TMP_BIT];
					next_yield = pwdata[MODE_YIELD_BIT];
				end
				default: next_state = state;
			endcase
		end
		case (state)
			ST_IDLE:
			begin
				if (apb_wr && paddr == CTRL_OFF && pwdata[CTRL_GO_BIT] && pwdata[2:0] <= OP_MAX)
				begin
					next_op = op_e'(pwdata[2:0]);
					next_done = 1'b0;
					next_poll_n = 1'b0;
					next_recheck = 1'b0;
					next_rst_cmd = 1'b0;
					next_poll_reads = 4'h0;
					next_cnt = 10'(SETUP_CYC - 1);
					next_state = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				next_flash_addr = pin_addr;
				next_dq_oe = is_wr;
				next_a9_hv = hv_op;
				next_oe_hv = hv_op && op != OP_VERIFY;
				// Writes under temporary unprotect wait until the reset pin high voltage has aged RSP_CYC cycles
				if (is_wr && (tmp_unprot || reset_hv) && !hv_full)
					next_cnt = cnt;
				else if (cnt != 10'h0)
					next_cnt = 10'(cnt - 10'h1);
				else
				begin
					next_cnt = (hv_op && is_wr) ? 10'(HV_PULSE_CYC - 1) : 10'(PULSE_CYC - 1);
					next_state = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				next_dq_oe = is_wr;
				next_a9_hv = hv_op;
				next_oe_hv = hv_op && op != OP_VERIFY;
				next_ce_n = 1'b0;
				next_we_n = !is_wr;
				next_oe_n = is_wr || oe_hv;
				if (cnt != 10'h0)
				begin
					next_cnt = 10'(cnt - 10'h1);
				end
				else
				begin
					next_ce_n = 1'b1;
					next_we_n = 1'b1;
					next_oe_n = 1'b1;
					if (!is_wr)
						next_rdata = dq_sync;
					next_cnt = 10'(RECOVER_CYC - 1);
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER:
			begin
				next_dq_oe = is_wr;
				next_a9_hv = hv_op;
				next_oe_hv = hv_op && op != OP_VERIFY;
				if (cnt != 10'h0)
					next_cnt = 10'(cnt - 10'h1);
				else
					next_state = ST_EVAL;
			end
			ST_EVAL:
			begin
				next_cnt = 10'(SETUP_CYC - 1);
				next_state = ST_SETUP;
				if (op == OP_POLL && !rst_cmd)
				begin
					if (poll_reads != 4'hf)
						next_poll_reads = 4'(poll_reads + 4'h1);
					if (!poll_n)
					begin
						next_tog = rdata[TOGGLE_BIT];
						next_poll_n = 1'b1;
					end
					else
					begin
						next_poll_n = 1'b0;
						if (rdata[TOGGLE_BIT] == tog)
						begin
							next_result = RES_OK;
							next_done = 1'b1;
							next_state = ST_IDLE;
						end
						else if (recheck)
							next_rst_cmd = 1'b1;
						else if (rdata[TIMEOUT_BIT])
							next_recheck = 1'b1;
						else if (yield)
						begin
							next_result = RES_YIELD;
							next_done = 1'b1;
							next_state = ST_IDLE;
						end
					end
				end
				else
				begin
					next_result = rst_cmd ? RES_FAIL : RES_OK;
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state <= ST_IDLE;
			op <= OP_READ;
			result <= RES_OK;
			cnt <= 10'h0;
			hv_age <= 9'h0;
			addr_reg <= 17'h0;
			wdata <= 8'h0;
			rdata <= 8'h0;
			poll_reads <= 4'h0;
			tmp_unprot <= 1'b0;
			yield <= 1'b0;
			done <= 1'b0;
			poll_n <= 1'b0;
			recheck <= 1'b0;
			rst_cmd <= 1'b0;
			tog <= 1'b0;
			flash_addr <= 17'h0;
			dq_out <= 8'h0;
			dq_oe <= 1'b0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			reset_n <= 1'b1;
			a9_hv <= 1'b0;
			oe_hv <= 1'b0;
			reset_hv <= 1'b0;
		end
		else
		begin
			state <= next_state;
			op <= next_op;
			result <= next_result;
			cnt <= next_cnt;
			hv_age <= next_hv_age;
			addr_reg <= next_addr_reg;
			wdata <= next_wdata;
			rdata <= next_rdata;
			poll_reads <= next_poll_reads;
			tmp_unprot <= next_tmp_unprot;
			yield <= next_yield;
			done <= next_done;
			poll_n <= next_poll_n;
			recheck <= next_recheck;
			rst_cmd <= next_rst_cmd;
			tog <= next_tog;
			flash_addr <= next_flash_addr;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			ce_n <= next_ce_n;
			oe_n <= next_oe_n;
			we_n <= next_we_n;
			reset_n <= 1'b1;
			a9_hv <= next_a9_hv;
			oe_hv <= next_oe_hv;
			reset_hv <= next_reset_hv;
		end
	end

	sequence s_we_active;
		!we_n;
	endsequence

	sequence s_poll_done;
		$rose(done) && op == OP_POLL;
	endsequence

	property p_write_combo;
		@(posedge sys_clk) disable iff (srst) s_we_active |-> !ce_n && oe_n && dq_oe;
	endproperty
	a_write_combo: assert property (p_write_combo) else $error("write strobe without chip select or with output strobe");

	property p_two_reads;
		@(posedge sys_clk) disable iff (srst) s_poll_done |-> poll_reads >= 4'h2;
	endproperty
	a_two_reads: assert property (p_two_reads) else $error("poll decided on fewer than two reads");

	property p_ok_same;
		@(posedge sys_clk) disable iff (srst) s_poll_done and result == RES_OK |-> rdata[TOGGLE_BIT] == tog;
	endproperty
	a_ok_same: assert property (p_ok_same) else $error("poll finished while toggle bit still changed");

	property p_recheck;
		@(posedge sys_clk) disable iff (srst) $rose(recheck) |-> rdata[TIMEOUT_BIT] && rdata[TOGGLE_BIT] != tog;
	endproperty
	a_recheck: assert property (p_recheck) else $error("recheck entered without timeout flag");

	property p_fail_reset;
		@(posedge sys_clk) disable iff (srst) $rose(rst_cmd) |-> ##[1:100] (!we_n && dq_out == RESET_CMD);
	endproperty
	a_fail_reset: assert property (p_fail_reset) else $error("failed poll did not write reset command");

	property p_restart;
		@(posedge sys_clk) disable iff (srst) $past(state) == ST_IDLE && state == ST_SETUP |-> !poll_n && !recheck && poll_reads == 4'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("poll did not restart from first step");

	property p_protect;
		@(posedge sys_clk) disable iff (srst)
			s_we_active and op == OP_PROTECT && !rst_cmd |-> a9_hv && oe_hv && oe_n && !flash_addr[A6_BIT] && !ce_n;
	endproperty
	a_protect: assert property (p_protect) else $error("protect pulse with wrong pin levels");

	property p_unprotect;
		@(posedge sys_clk) disable iff (srst)
			s_we_active and op == OP_UNPROTECT && !rst_cmd |-> a9_hv && oe_hv && flash_addr[A6_BIT] && !ce_n;
	endproperty
	a_unprotect: assert property (p_unprotect) else $error("unprotect pulse with wrong pin levels");

	property p_rsp;
		@(posedge sys_clk) disable iff (srst) s_we_active and reset_hv |-> hv_age == RSP_MAX;
	endproperty
	a_rsp: assert property (p_rsp) else $error("write too soon after reset pin high voltage");
endmodule

// ===== core/flash_host_pkg.sv
// Constants, register map and types for the flash pin-level host controller
package flash_host_pkg;
	localparam int CLK_NS = 10;
	localparam int T_SETUP_NS = 30;
	localparam int T_PULSE_NS = 120;
	localparam int T_HV_PULSE_NS = 1000;
	localparam int T_RECOVER_NS = 50;
	localparam int T_RSP_US = 4;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HV_PULSE_CYC = (T_HV_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
	localparam int RSP_CYC = (T_RSP_US * 1000 + CLK_NS - 1) / CLK_NS;

	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] ADDR_OFF = 8'h04;
	localparam logic [7:0] WDATA_OFF = 8'h08;
	localparam logic [7:0] STATUS_OFF = 8'h0c;
	localparam logic [7:0] MODE_OFF = 8'h10;

	localparam int CTRL_GO_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_RES_LSB = 2;
	localparam int STAT_HVRDY_BIT = 4;
	localparam int STAT_RDATA_LSB = 8;
	localparam int MODE_TMP_BIT = 0;
	localparam int MODE_YIELD_BIT = 1;

	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	localparam int A1_BIT = 1;
	localparam int A6_BIT = 6;
	localparam logic [7:0] RESET_CMD = 8'hf0;
	localparam logic [2:0] OP_MAX = 3'h5;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WRITE = 3'h1,
		OP_POLL = 3'h2,
		OP_PROTECT = 3'h3,
		OP_UNPROTECT = 3'h4,
		OP_VERIFY = 3'h5
	} op_e;

	typedef enum logic [1:0] {
		RES_OK = 2'h0,
		RES_FAIL = 2'h1,
		RES_YIELD = 2'h2
	} result_e;
endpackage

// ===== test/flash_dev_model.sv
// Behavioural flash device answering the host's pin-level cycles
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0] PROG_CMD = 8'ha0,
	parameter logic [7:0] ID_CODE = 8'hc3, // Arbitrary identity value
	parameter logic [7:0] INIT = 8'h3c,
	parameter int BUSY_READS = 3
)
(
	input wire logic [16:0] flash_addr,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic a9_hv,
	input wire logic oe_hv,
	input wire logic reset_hv,
	input wire logic stall,
	input wire logic tmo,
	output logic [7:0] dq_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [16];
	logic [7:0] prot;
	logic [7:0] last;
	logic [7:0] rv;
	logic tog;
	logic pend;
	int busy;
	realtime t0;
	wire rd = ~ce_n & ~oe_n;
	// High voltage on the output strobe counts as a logical one there
	wire wr = ~ce_n & ~we_n & (oe_n | oe_hv);
	wire [2:0] sec = flash_addr[16:14];
	initial
	begin
		foreach (mem[i])
			mem[i] = INIT;
		prot = 8'h00;
		tog = 1'b0;
		pend = 1'b0;
		busy = 0;
		last = 8'h00;
		t0 = 0.0;
	end
	always_comb
	begin
		if (a9_hv)
			rv = flash_addr[A1_BIT] ? {7'h0, prot[sec]} : ID_CODE;
		else if (busy > 0)
			rv = {1'b0, tog, tmo, 5'h00};
		else
			rv = mem[flash_addr[3:0]];
	end
	// Released bus shows the inverse of the last byte, never a stale copy
	assign dq_in = (rd && !dq_oe) ? rv : ~last;
	always @(negedge rd)
	begin
		last = rv;
		if (busy > 0)
			tog = ~tog;
		if (busy > 0 && !stall)
			busy--;
	end
	always @(posedge wr)
		t0 = $realtime;
	always @(negedge wr)
	begin
		if ($realtime - t0 >= 5.0)
		begin
			if (a9_hv && oe_hv)
				prot = flash_addr[A6_BIT] ? 8'h00 : (prot | (8'h01 << sec));
			else if (dq_out == RESET_CMD)
			begin
				busy = 0;
				pend = 1'b0;
			end
			else if (busy > 0)
				pend = 1'b0;
			else if (pend)
			begin
				pend = 1'b0;
				if (!prot[sec] || reset_hv)
				begin
					mem[flash_addr[3:0]] = dq_out;
					busy = BUSY_READS;
				end
			end
			else
				pend = (dq_out == PROG_CMD);
		end
	end
endmodule

// ===== test/flash_host_bench.sv
// Self-checking bench for the flash pin-level host controller
module flash_host_bench;
	import flash_host_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] PROG_CMD = 8'ha0;
	localparam logic [7:0] INIT = 8'h3c;
	logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, dq_oe, ce_n, oe_n, we_n;
	logic reset_n, a9_hv, oe_hv, reset_hv, stall, tmo, err;
	logic [7:0] paddr, dq_in, dq_out;
	logic [31:0] pwdata, prdata, st, q;
	logic [16:0] flash_addr;
	int n_mismatch, n_tests;
	flash_host dut_u (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .reset_n(reset_n), .a9_hv(a9_hv), .oe_hv(oe_hv), .reset_hv(reset_hv));
	flash_dev_model #(.PROG_CMD(PROG_CMD), .INIT(INIT)) model_u (.flash_addr(flash_addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a9_hv(a9_hv), .oe_hv(oe_hv),
		.reset_hv(reset_hv), .stall(stall), .tmo(tmo), .dq_in(dq_in));
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic stop_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				n_mismatch++;
				stop_test();
			end
			@(posedge sys_clk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Starts one operation and waits for done, leaving the final status in st
	task automatic run(input op_e op, input logic [16:0] a, input logic [7:0] d);
		int n;
		n = 0;
		apb(1'b1, ADDR_OFF, {15'h0, a});
		apb(1'b1, WDATA_OFF, {24'h0, d});
		apb(1'b1, CTRL_OFF, (32'h1 << CTRL_GO_BIT) | {29'h0, op});
		do
		begin
			apb(1'b0, STATUS_OFF, 32'h0);
			n++;
		end
		while (q[STAT_DONE_BIT] !== 1'b1 && n < 2000);
		// An operation that never finishes counts against the run
		if (q[STAT_DONE_BIT] !== 1'b1)
			n_mismatch++;
		st = q;
		apb(1'b1, STATUS_OFF, 32'h1 << STAT_DONE_BIT);
	endtask
	task automatic prog(input logic [16:0] a, input logic [7:0] d, input logic [1:0] res);
		run(OP_WRITE, a, PROG_CMD);
		run(OP_WRITE, a, d);
		run(OP_POLL, a, 8'h00);
		chk({6'h0, st[STAT_RES_LSB+:2]}, {6'h0, res});
	endtask
	task automatic rd(input logic [16:0] a, input logic [7:0] exp);
		run(OP_READ, a, 8'h00);
		chk(st[STAT_RDATA_LSB+:8], exp);
	endtask
	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stall = 1'b0;
		tmo = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		chk({reset_n, ce_n, oe_n, we_n, dq_oe, a9_hv, oe_hv, reset_hv}, 8'hf0);
		apb(1'b0, 8'h20, 32'h0);
		chk({7'h0, err}, 8'h01);
		rd(17'h3, INIT);
		prog(17'h2, 8'h81, RES_OK);
		rd(17'h2, 8'h81);
		run(OP_WRITE, 17'h5, 8'h42);
		rd(17'h5, INIT);
		run(OP_PROTECT, 17'h0, 8'h00);
		run(OP_VERIFY, 17'h1, 8'h00);
		chk(st[STAT_RDATA_LSB+:8], 8'h01);
		run(OP_VERIFY, 17'h4000, 8'h00);
		chk(st[STAT_RDATA_LSB+:8], 8'h00);
		prog(17'h2, 8'h18, RES_OK);
		rd(17'h2, 8'h81);
		apb(1'b1, MODE_OFF, 32'h1);
		apb(1'b0, MODE_OFF, 32'h0);
		chk(q[7:0], 8'h01);
		prog(17'h2, 8'h18, RES_OK);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk({7'h0, q[STAT_HVRDY_BIT]}, 8'h01);
		rd(17'h2, 8'h18);
		apb(1'b1, MODE_OFF, 32'h0);
		prog(17'h2, 8'h77, RES_OK);
		rd(17'h2, 8'h18);
		stall <= 1'b1;
		apb(1'b1, MODE_OFF, 32'h2);
		prog(17'h4001, 8'h55, RES_YIELD);
		stall <= 1'b0;
		apb(1'b1, MODE_OFF, 32'h0);
		run(OP_POLL, 17'h4001, 8'h00);
		chk({6'h0, st[STAT_RES_LSB+:2]}, {6'h0, RES_OK});
		stall <= 1'b1;
		tmo <= 1'b1;
		prog(17'h4003, 8'h66, RES_FAIL);
		stall <= 1'b0;
		tmo <= 1'b0;
		rd(17'h4003, 8'h66);
		// Only sector zero is protected here; protecting all first is advised, not required
		run(OP_UNPROTECT, 17'h0, 8'h00);
		run(OP_VERIFY, 17'h1, 8'h00);
		chk(st[STAT_RDATA_LSB+:8], 8'h00);
		stop_test();
	end
	// The whole sequence needs well under ten thousand cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end
endmodule
